// ### logic/src_audio_source.sv
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Operation
// - sync pin low shares clock one; high per-line
// - synchronous mode: unused clocks tied low
// - samples are MSB-first two's complement
// - data sampled on its bit clock rising edge
// - parallel control: pins set one common format
// - format pins settled while power-down held low
// - serial control: per-pair 3-bit format field
// - change field only after soft mute reaches zero
// - TDM only synchronous, line one, others ignored
// - TDM: unused data inputs tied high
// - never TDM in asynchronous mode
// - bit clock at most 256 per sample
// - codes 0,1,2: LSB16, LSB20, MSB24 formats
// - code 3: I2S, 24 or 16 bit
// - code 4: 24-bit LSB justified
// - codes 5-7: TDM, 256 bit clocks
// - bit clock rise never at frame edge
// - power-down low resets; held 150 ns
module src_audio_source
    import src_port_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    src_link_if.source       link
);

    logic [CTRL_W-1:0] ctrl_reg;
    logic [WORD_W-1:0] data_reg [2*LANES];
    logic              wr_pend_reg;
    logic              rd_pend_reg;
    logic              rd_ready_reg;
    logic [7:0]        addr_reg;
    logic [1:0]        pd_cnt_reg;
    logic              pdn_reg;
    logic [FMT_W-1:0]  fmt_pin_reg;
    logic              async_pin_reg;
    logic              bclk_reg;
    logic              lrck_reg;
    logic [LANES-1:0]  sdata_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic [CNT_W-1:0]  frame_last;
    logic              bad_cfg;
    logic              running;
    logic              take;
    logic              tdm;
    logic [CNT_W-1:0]  half;
    logic [LANES-1:0]  bit_next;
    logic [31:0]       rd_value;

    assign take      = hsel && htrans[1] && hready;
    assign hreadyout = !(rd_pend_reg && !rd_ready_reg);
    assign hresp     = 1'b0;
    assign tdm       = is_tdm(fmt_pin_reg);
    assign half      = half_bits(fmt_pin_reg);
    // TDM cannot run with per-line clocks, so the source refuses to start
    assign bad_cfg   = async_pin_reg && tdm;
    assign running   = ctrl_reg[CTRL_RUN_BIT] && pdn_reg && !bad_cfg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg  <= 1'b0;
            rd_pend_reg  <= 1'b0;
            rd_ready_reg <= 1'b0;
            addr_reg     <= '0;
        end else begin
            rd_ready_reg <= rd_pend_reg && !rd_ready_reg;
            if (take) begin
                wr_pend_reg <= hwrite;
                rd_pend_reg <= !hwrite;
                addr_reg    <= haddr[7:0];
            end else if (hreadyout) begin
                wr_pend_reg <= 1'b0;
                rd_pend_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_value = '0;
        if (addr_reg == REG_CTRL) begin
            rd_value = {26'h0, ctrl_reg};
        end else if (addr_reg == REG_STATUS) begin
            rd_value = {21'h0, bad_cfg, running, pdn_reg, cnt_reg};
        end else if (addr_reg[7:5] == REG_DATA0[7:5] && addr_reg[1:0] == 2'h0) begin
            rd_value = {8'h0, data_reg[addr_reg[4:2]]};
        end
    end

    // reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_pend_reg && !rd_ready_reg) begin
            hrdata <= rd_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
            for (int i = 0; i < 2*LANES; i++) begin
                data_reg[i] <= '0;
            end
        end else if (wr_pend_reg) begin
            if (addr_reg == REG_CTRL) begin
                ctrl_reg <= hwdata[CTRL_W-1:0];
            end else if (addr_reg[7:5] == REG_DATA0[7:5] && addr_reg[1:0] == 2'h0) begin
                data_reg[addr_reg[4:2]] <= hwdata[WORD_W-1:0];
            end
        end
    end

    // power-down stays low a minimum time; format straps move only then
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_cnt_reg    <= '0;
            pdn_reg       <= 1'b0;
            fmt_pin_reg   <= FMT_LSB16;
            async_pin_reg <= 1'b0;
        end else begin
            if (!ctrl_reg[CTRL_PDN_BIT]) begin
                pd_cnt_reg <= '0;
                pdn_reg    <= 1'b0;
            end else if (pd_cnt_reg < PD_CYCLES) begin
                pd_cnt_reg <= pd_cnt_reg + 2'h1;
            end else begin
                pdn_reg <= 1'b1;
            end
            if (!pdn_reg) begin
                fmt_pin_reg   <= ctrl_reg[CTRL_FMT_LSB +: FMT_W];
                async_pin_reg <= ctrl_reg[CTRL_ASYNC_BIT];
            end
        end
    end

    assign frame_last = tdm ? TDM_LAST_BIT : CNT_W'(2*half - 1);
    assign cnt_next   = (cnt_reg == frame_last) ? '0 : CNT_W'(cnt_reg + 1'b1);

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_bit
            logic             second;
            logic [CNT_W-1:0] p;
            logic [4:0]       slot_p;
            always_comb begin
                second = cnt_next >= half;
                p      = second ? CNT_W'(cnt_next - half) : cnt_next;
                slot_p = cnt_next[4:0];
                if (tdm) begin
                    if (g != 0) begin
                        bit_next[g] = 1'b1;
                    end else if (fmt_pin_reg == FMT_TDM_MSB) begin
                        bit_next[g] = (slot_p <= MSB_LAST_IDX[4:0])
                                    && data_reg[cnt_next[7:5]][5'(MSB_LAST_IDX[4:0] - slot_p)];
                    end else begin
                        bit_next[g] = (slot_p != 5'h0) && (slot_p <= I2S_LAST_IDX[4:0])
                                    && data_reg[cnt_next[7:5]][5'(I2S_LAST_IDX[4:0] - slot_p)];
                    end
                end else if (fmt_pin_reg == FMT_I2S) begin
                    // one bit late: the previous word's LSB opens each half
                    if (p == '0) begin
                        bit_next[g] = data_reg[2*g + int'(!second)][0];
                    end else begin
                        bit_next[g] = data_reg[2*g + int'(second)][5'(I2S_LAST_IDX - p)];
                    end
                end else begin
                    bit_next[g] = data_reg[2*g + int'(second)][5'(MSB_LAST_IDX - p)];
                end
            end
        end
    endgenerate

    // data and frame clock move with the falling bit clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_reg  <= 1'b0;
            lrck_reg  <= 1'b0;
            sdata_reg <= '0;
            cnt_reg   <= '0;
        end else if (!running) begin
            // a new run opens on bit 0, not where the last run stopped
            bclk_reg  <= 1'b0;
            cnt_reg   <= frame_last;
            sdata_reg <= bit_next;
        end else begin
            bclk_reg <= !bclk_reg;
            if (bclk_reg) begin
                cnt_reg   <= cnt_next;
                sdata_reg <= bit_next;
                if (fmt_pin_reg == FMT_TDM_MSB) begin
                    lrck_reg <= cnt_next < SLOT_BITS;
                end else if (tdm) begin
                    lrck_reg <= cnt_next >= SLOT_BITS;
                end else begin
                    lrck_reg <= (cnt_next < half) ^ (fmt_pin_reg == FMT_I2S);
                end
            end
        end
    end

    generate
        for (g = 0; g < LANES; g++) begin : g_pin
            // synchronous mode leaves lines two to four unclocked, held low
            assign link.input_bit_clock[g]   = (g == 0 || async_pin_reg) && bclk_reg;
            assign link.input_frame_clock[g] = (g == 0 || async_pin_reg) && lrck_reg;
        end
    endgenerate

    assign link.serial_data_in     = sdata_reg;
    assign link.sync_async_select  = async_pin_reg;
    assign link.format_select_pins = fmt_pin_reg;
    assign link.power_down_n       = pdn_reg;

endmodule

// ### logic/src_input_receiver.sv
`timescale 1ns/1ps
module src_input_receiver
    import src_port_pkg::*;
(
    src_link_if.receiver            link,
    input  wire logic               control_select,
    input  wire logic [FMT_W-1:0]   pair_format_field [LANES],
    output logic      [LANES-1:0]   lane_clock,
    output logic      [WORD_W-1:0]  sample_word [LANES],
    output logic      [CHAN_W-1:0]  sample_chan [LANES],
    output logic      [LANES-1:0]   sample_valid
);

    logic [FMT_W-1:0] fmt_eff [LANES];
    logic             line0_tdm;

    assign line0_tdm = is_tdm(fmt_eff[0]);

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic              lrck_in;
            logic              sdata_in;
            logic              en_raw;
            logic [FMT_W-1:0]  fmt_s;
            logic              en_s;
            logic              lrck_prev_reg;
            logic [CNT_W-1:0]  cnt_reg;
            logic [CNT_W-1:0]  cnt_next;
            logic [WORD_W-1:0] shift_reg;
            logic [WORD_W-1:0] shift_next;
            logic [WORD_W-1:0] word_reg;
            logic [CHAN_W-1:0] chan_reg;
            logic              valid_reg;
            logic              edge_seen;
            logic              restart;
            logic [CNT_W-1:0]  idx;
            logic              cap;
            logic [WORD_W-1:0] word;
            logic [CHAN_W-1:0] chan;

            // the sync select pin is a strap, fixed while the link runs,
            // so it steers the clock without a crossing
            assign lane_clock[g] = link.sync_async_select ? link.input_bit_clock[g]
                                                          : link.input_bit_clock[0];
            assign lrck_in = link.sync_async_select ? link.input_frame_clock[g]
                                                    : link.input_frame_clock[0];
            assign sdata_in = link.serial_data_in[g];

            assign fmt_eff[g] = control_select ? pair_format_field[g]
                                               : link.format_select_pins;
            // lines two to four fall silent while line one carries TDM
            assign en_raw = (g == 0) || !line0_tdm;

            sync_2ff #(
                .W(FMT_W + 1)
            ) u_cfg_sync (
                .clk   (lane_clock[g]),
                .rst_n (link.power_down_n),
                .d     ({en_raw, fmt_eff[g]}),
                .q     ({en_s, fmt_s})
            );

            always_comb begin
                edge_seen  = lrck_in != lrck_prev_reg;
                // TDM frames start on one edge only, picked by the code
                if (is_tdm(fmt_s)) begin
                    restart = edge_seen && (lrck_in == (fmt_s == FMT_TDM_MSB));
                end else begin
                    restart = edge_seen;
                end
                idx        = restart ? '0 : CNT_W'(cnt_reg + 1'b1);
                shift_next = {shift_reg[WORD_W-2:0], sdata_in};
                cap        = 1'b0;
                word       = shift_next;
                chan       = '0;
                case (fmt_s)
                    FMT_LSB16, FMT_LSB20, FMT_LSB24: begin
                        // last N bits before the edge, left aligned
                        cap  = edge_seen;
                        word = shift_reg << (CNT_W'(WORD_W) - half_bits(fmt_s));
                        chan = {2'b00, ~lrck_prev_reg};
                    end
                    FMT_MSB24: begin
                        cap  = idx == MSB_LAST_IDX;
                        chan = {2'b00, ~lrck_in};
                    end
                    FMT_I2S: begin
                        // a short half puts its LSB on the first bit
                        // after the edge
                        if (edge_seen && cnt_reg < I2S_LAST_IDX) begin
                            cap  = cnt_reg != '0;
                            word = shift_next << (MSB_LAST_IDX - cnt_reg);
                            chan = {2'b00, lrck_prev_reg};
                        end else begin
                            cap  = idx == I2S_LAST_IDX;
                            chan = {2'b00, lrck_in};
                        end
                    end
                    default: begin
                        if (fmt_s == FMT_TDM_MSB) begin
                            cap = idx[4:0] == MSB_LAST_IDX[4:0];
                        end else begin
                            cap = idx[4:0] == I2S_LAST_IDX[4:0];
                        end
                        chan = idx[7:5];
                    end
                endcase
                if (restart || is_tdm(fmt_s) || cnt_reg != TDM_LAST_BIT) begin
                    cnt_next = idx;
                end else begin
                    cnt_next = cnt_reg;
                end
            end

            // shift on every rising bit clock edge; count too, except that outside TDM it holds at TDM_LAST_BIT until a frame edge
            always_ff @(posedge lane_clock[g] or negedge link.power_down_n) begin
                if (!link.power_down_n) begin
                    lrck_prev_reg <= 1'b0;
                    cnt_reg       <= '0;
                    shift_reg     <= '0;
                end else begin
                    lrck_prev_reg <= lrck_in;
                    cnt_reg       <= cnt_next;
                    shift_reg     <= shift_next;
                end
            end

            always_ff @(posedge lane_clock[g] or negedge link.power_down_n) begin
                if (!link.power_down_n) begin
                    valid_reg <= 1'b0;
                    word_reg  <= '0;
                    chan_reg  <= '0;
                end else begin
                    valid_reg <= cap && en_s;
                    if (cap && en_s) begin
                        word_reg <= word;
                        chan_reg <= chan;
                    end
                end
            end

            assign sample_word[g]  = word_reg;
            assign sample_chan[g]  = chan_reg;
            assign sample_valid[g] = valid_reg;
        end
    endgenerate

endmodule

// ### logic/src_link_if.sv
`timescale 1ns/1ps
interface src_link_if
    import src_port_pkg::*;
;
    logic [LANES-1:0] serial_data_in;
    logic [LANES-1:0] input_frame_clock;
    logic [LANES-1:0] input_bit_clock;
    logic             sync_async_select;
    logic [FMT_W-1:0] format_select_pins;
    logic             power_down_n;

    modport source (
        output serial_data_in,
        output input_frame_clock,
        output input_bit_clock,
        output sync_async_select,
        output format_select_pins,
        output power_down_n
    );

    modport receiver (
        input serial_data_in,
        input input_frame_clock,
        input input_bit_clock,
        input sync_async_select,
        input format_select_pins,
        input power_down_n
    );
endinterface

// ### logic/src_port_pkg.sv
package src_port_pkg;

    localparam int LANES  = 4;
    localparam int WORD_W = 24;
    localparam int FMT_W  = 3;
    localparam int CHAN_W = 3;
    localparam int CNT_W  = 8;

    localparam logic [FMT_W-1:0] FMT_LSB16   = 3'h0;
    localparam logic [FMT_W-1:0] FMT_LSB20   = 3'h1;
    localparam logic [FMT_W-1:0] FMT_MSB24   = 3'h2;
    localparam logic [FMT_W-1:0] FMT_I2S     = 3'h3;
    localparam logic [FMT_W-1:0] FMT_LSB24   = 3'h4;
    localparam logic [FMT_W-1:0] FMT_TDM_MSB = 3'h5;
    localparam logic [FMT_W-1:0] FMT_TDM_I2S = 3'h6;

    localparam logic [CNT_W-1:0] SLOT_BITS     = 8'h20;
    localparam logic [CNT_W-1:0] TDM_LAST_BIT  = 8'hFF;
    localparam logic [CNT_W-1:0] MSB_LAST_IDX  = 8'h17;
    localparam logic [CNT_W-1:0] I2S_LAST_IDX  = 8'h18;
    localparam logic [CNT_W-1:0] HALF_BITS_16  = 8'h10;
    localparam logic [CNT_W-1:0] HALF_BITS_20  = 8'h14;
    localparam logic [CNT_W-1:0] HALF_BITS_24  = 8'h18;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA0  = 8'h20;

    localparam int CTRL_W         = 6;
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_FMT_LSB   = 1;
    localparam int CTRL_ASYNC_BIT = 4;
    localparam int CTRL_PDN_BIT   = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    localparam int PD_MIN_NS = 150;
    localparam int HCLK_NS   = 100;
    localparam logic [1:0] PD_CYCLES = 2'((PD_MIN_NS + HCLK_NS - 1) / HCLK_NS);

    function automatic logic is_tdm(input logic [FMT_W-1:0] f);
        return f >= FMT_TDM_MSB;
    endfunction

    // bits carried per half frame for the stereo codes
    function automatic logic [CNT_W-1:0] half_bits(input logic [FMT_W-1:0] f);
        if (f == FMT_LSB16) begin
            return HALF_BITS_16;
        end else if (f == FMT_LSB20) begin
            return HALF_BITS_20;
        end
        return HALF_BITS_24;
    endfunction

endpackage

// ### logic/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // meta_reg is read by q only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ### tb/src_input_serial_port_sva.sv
`timescale 1ns/1ps
module src_input_serial_port_sva
    import src_port_pkg::*;
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic [LANES-1:0] serial_data_in,
    input wire logic [LANES-1:0] input_frame_clock,
    input wire logic [LANES-1:0] input_bit_clock,
    input wire logic             sync_async_select,
    input wire logic [FMT_W-1:0] format_select_pins,
    input wire logic             power_down_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic       fr_q;
    logic       fseen;
    logic [9:0] fcnt;
    wire        start_lvl = !(format_select_pins == FMT_I2S || format_select_pins >= FMT_TDM_I2S);
    wire        fstart    = power_down_n && (fr_q != input_frame_clock[0])
                            && (input_frame_clock[0] == start_lvl);

    // frame period in hclk cycles: the bit clock runs at half of hclk
    function automatic logic [9:0] frame_hclk(input logic [FMT_W-1:0] f);
        if (f == FMT_LSB16) begin
            return 10'h040;
        end else if (f == FMT_LSB20) begin
            return 10'h050;
        end else if (f >= FMT_TDM_MSB) begin
            return 10'h200;
        end
        return 10'h060;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fr_q <= 1'b0;
        end else begin
            fr_q <= input_frame_clock[0];
        end
    end

    // the first edge after release only arms the counter, the partial frame is not judged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fcnt  <= 10'h000;
            fseen <= 1'b0;
        end else if (!power_down_n) begin
            fcnt  <= 10'h000;
            fseen <= 1'b0;
        end else if (fstart) begin
            fcnt  <= 10'h001;
            fseen <= 1'b1;
        end else begin
            fcnt  <= fcnt + 10'h001;
        end
    end

    property p_sync_spare_clocks_low;
        !sync_async_select && power_down_n |->
            input_frame_clock[3:1] == 3'h0 && input_bit_clock[3:1] == 3'h0;
    endproperty
    a_sync_spare_clocks_low: assert property (p_sync_spare_clocks_low)
        else $error("spare clocks move in synchronous mode");

    property p_tdm_spare_data_high;
        input_bit_clock[0] && format_select_pins >= FMT_TDM_MSB |-> &serial_data_in[3:1];
    endproperty
    a_tdm_spare_data_high: assert property (p_tdm_spare_data_high)
        else $error("spare data lines not high in TDM");

    property p_pins_frozen;
        power_down_n && $past(power_down_n) |->
            $stable(format_select_pins) && $stable(sync_async_select);
    endproperty
    a_pins_frozen: assert property (p_pins_frozen)
        else $error("format or mode pins changed out of power-down");

    property p_no_async_tdm;
        input_bit_clock[0] |-> !(sync_async_select && format_select_pins >= FMT_TDM_MSB);
    endproperty
    a_no_async_tdm: assert property (p_no_async_tdm)
        else $error("TDM running in asynchronous mode");

    property p_frame_off_bit_rise;
        $rose(input_bit_clock[0]) |-> $stable(input_frame_clock[0]);
    endproperty
    a_frame_off_bit_rise: assert property (p_frame_off_bit_rise)
        else $error("frame clock moved at bit clock rise");

    property p_pdn_width;
        $fell(power_down_n) |-> !power_down_n [*2];
    endproperty
    a_pdn_width: assert property (p_pdn_width)
        else $error("power-down pulse too short");

    property p_bit_clock_half_rate;
        $rose(input_bit_clock[0]) |=> $fell(input_bit_clock[0]) ##1 !$fell(input_bit_clock[0]);
    endproperty
    a_bit_clock_half_rate: assert property (p_bit_clock_half_rate)
        else $error("bit clock period wrong");

    property p_frame_length;
        fstart && fseen |-> fcnt == frame_hclk(format_select_pins);
    endproperty
    a_frame_length: assert property (p_frame_length)
        else $error("frame length wrong for format");
endmodule

// ### tb/src_input_serial_port_tb_top.sv
`timescale 1ns/1ps
module src_input_serial_port_tb_top
    import src_port_pkg::*;
;
    logic              hclk;
    logic              hresetn;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic              control_select;
    logic [FMT_W-1:0]  fields [LANES];
    logic [LANES-1:0]  lane_clock;
    logic [WORD_W-1:0] sample_word [LANES];
    logic [CHAN_W-1:0] sample_chan [LANES];
    logic [LANES-1:0]  sample_valid;
    logic [23:0]       dat [8];
    logic [31:0]       rd;
    logic [FMT_W-1:0]  cur_fmt;
    logic              collect;
    int                n_seen [LANES];
    int                n_fail;
    int                cmp_count;
    int                cyc;

    src_link_if link_if ();

    src_audio_source src_audio_source_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_if.source)
    );

    src_input_receiver src_input_receiver_inst (
        .link(link_if.receiver), .control_select(control_select), .pair_format_field(fields),
        .lane_clock(lane_clock), .sample_word(sample_word), .sample_chan(sample_chan),
        .sample_valid(sample_valid)
    );

    src_input_serial_port_sva src_input_serial_port_sva_inst (
        .hclk(hclk), .hresetn(hresetn), .serial_data_in(link_if.serial_data_in),
        .input_frame_clock(link_if.input_frame_clock),
        .input_bit_clock(link_if.input_bit_clock),
        .sync_async_select(link_if.sync_async_select),
        .format_select_pins(link_if.format_select_pins), .power_down_n(link_if.power_down_n)
    );

    task automatic end_sim;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    function automatic int bit_len(input logic [FMT_W-1:0] f);
        return (f == FMT_LSB16) ? 32 : (f == FMT_LSB20) ? 40 : (f >= FMT_TDM_MSB) ? 256 : 48;
    endfunction

    // short formats carry only the top bits, received words are padded low with zero
    function automatic logic [23:0] exp_word(input int g, input logic [CHAN_W-1:0] c);
        logic [23:0] v;
        v = dat[(cur_fmt >= FMT_TDM_MSB) ? int'(c) : 2 * g + int'(c[0])];
        if (cur_fmt == FMT_LSB16) begin
            return v & 24'hFFFF00;
        end else if (cur_fmt == FMT_LSB20) begin
            return v & 24'hFFFFF0;
        end
        return v;
    endfunction

    task automatic run_cfg(input logic [FMT_W-1:0] f, input logic asy, input logic cs);
        int fl;
        int need;
        fl = bit_len(f);
        ahb_write({24'h0, REG_CTRL}, 32'h0);
        for (int k = 0; k < 8; k++) begin
            dat[k] = 24'($urandom);
            ahb_write({24'h0, REG_DATA0} + 32'(4 * k), {8'h0, dat[k]});
        end
        control_select <= cs;
        for (int g = 0; g < LANES; g++) begin
            fields[g] <= cs ? f : 3'($urandom);
        end
        cur_fmt = f;
        ahb_write({24'h0, REG_CTRL}, {26'h0, 1'b0, asy, f, 1'b0});
        ahb_write({24'h0, REG_CTRL}, {26'h0, 1'b1, asy, f, 1'b1});
        repeat (6 * fl) @(posedge hclk);
        ahb_read({24'h0, REG_STATUS}, rd);
        check("status run", rd[9:8], 32'h3);
        n_seen = '{default: 0};
        collect = 1'b1;
        repeat (8 * fl) @(posedge hclk);
        collect = 1'b0;
        for (int g = 0; g < LANES; g++) begin
            need = (f < FMT_TDM_MSB) ? 6 : (g == 0) ? 24 : 0;
            check("lane count", n_seen[g] >= need && (need > 0 || n_seen[g] == 0), 1);
        end
    endtask

    always @(posedge hclk) begin
        if (collect) begin
            for (int g = 0; g < LANES; g++) begin
                if (lane_clock[g] === 1'b1 && sample_valid[g] === 1'b1) begin
                    n_seen[g]++;
                    check("sample chan", sample_chan[g] < ((cur_fmt >= FMT_TDM_MSB) ? 8 : 2), 1);
                    check("sample word", {8'h0, sample_word[g]}, {8'h0, exp_word(g, sample_chan[g])});
                end
            end
        end
    end

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            end_sim;
        end
    end

    initial begin
        void'($urandom(32'h39183BCC));
        {hresetn, hsel, hwrite, collect, control_select} = 5'h00;
        {haddr, hwdata, htrans, hsize, cur_fmt} = '0;
        fields = '{default: 3'h0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb_read({24'h0, REG_CTRL}, rd);
        check("ctrl reset", rd, {26'h0, CTRL_RESET});
        ahb_write(32'h0000_0080, 32'hFFFF_FFFF);
        ahb_read(32'h0000_0080, rd);
        check("unmapped read", rd, 32'h0);
        ahb_read({24'h0, REG_CTRL}, rd);
        check("ctrl untouched", rd, 32'h0);
        for (int k = 0; k < 8; k++) begin
            run_cfg(3'(k), 1'b0, k[0]);
        end
        run_cfg(FMT_MSB24, 1'b1, 1'b1);
        run_cfg(FMT_LSB16, 1'b1, 1'b0);
        run_cfg(FMT_I2S, 1'b1, 1'b1);
        ahb_write({24'h0, REG_CTRL}, 32'h0);
        ahb_write({24'h0, REG_CTRL}, {26'h0, 1'b1, 1'b1, FMT_TDM_MSB, 1'b1});
        repeat (20) @(posedge hclk);
        ahb_read({24'h0, REG_STATUS}, rd);
        check("async tdm refused", rd[10:9], 32'h2);
        end_sim;
    end
endmodule
